// [hdl/ccis_slave.sv]
// two-wire serial slave that decodes capacitor code commands and nibble programming
//
// Notes on behaviour
// - device is only a target; it never starts a transfer.
// - data sampled on clock rise; start is data falling while clock high.
// - device pulls data low during the ninth clock after each accepted byte.
// - first byte holds seven-bit select address and direction bit, zero means write.
// - high byte bit 7 picks retained store write or working register write.
// - volatile write: high bit 0 is code bit 8, low byte code 7..0.
// - volatile write enters volatile mode until power loss or set-retained command.
// - retained write: bits 6..5 nibble address, bit 4 zero, bits 3..0 ignored.
// - nibble 2 holds code bit 8, nibble 1 bits 7..4, nibble 0 bits 3..0.
// - retained write keeps the mode and is accepted in either mode.
// - nibbles are independent; unwritten nibbles keep their value.
// - internal programming ends only at the stop that follows the command.
// - stored code reaches retained control register only on read or power-up.
// - high upper nibble 0x9 selects retained mode, working register untouched.
// - power-up starts in retained mode, working register cleared.
`timescale 1ns/10ps
module ccis_slave
    import ccis_pkg::*;
#(
    parameter logic [ADDR_W-1:0] DEV_ADDR   = 7'h2A,  // arbitrary select address
    parameter logic [CODE_W-1:0] STORE_INIT = 9'h000  // retained contents at power-up
)
(
    // clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              ce,
    // serial pins
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    // capacitor and status
    output logic [CODE_W-1:0]      capacitor_code,
    output logic                   retained_mode,
    output logic [CODE_W-1:0]      working_code_register,
    output logic [CODE_W-1:0]      retained_code_store,
    output logic                   prog_active,
    output logic [1:0]             last_nibble
);

    // the nibble map and address compare are written for these exact widths
    if (ADDR_W != 7 || CODE_W != 9)
    begin : g_width_chk
        $error("select address must be seven bits and the code nine bits");
    end

    // ********************************
    // pin synchronisers
    // ********************************
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end
        else if (ce)
        begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // ********************************
    // protocol state
    // ********************************
    ccis_state_t         state, next_state;
    logic [BITCNT_W-1:0] bitcnt, next_bitcnt;
    logic [BYTE_W-1:0]   shreg, next_shreg;
    ccis_cmd_t           cmd, next_cmd;
    ccis_prog_t          prog, next_prog;
    logic [CODE_W-1:0]   ctrl, next_ctrl;
    logic [CODE_W-1:0]   next_work, next_store;
    logic [CODE_W-1:0]   next_cap;
    logic [1:0]          next_last;
    logic                next_oe, next_ret;
    logic                byte_done;

    assign byte_done = (bitcnt == BITS_PER_BYTE);

    always_comb
    begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_cmd = cmd;
        next_prog = prog;
        next_ctrl = ctrl;
        next_work = working_code_register;
        next_store = retained_code_store;
        next_last = last_nibble;
        next_oe = sda_oe;
        next_ret = retained_mode;
        if (bus_start)
        begin
            // repeated start restarts decoding but not a pending program
            next_state = CCIS_ADDR;
            next_bitcnt = '0;
            next_oe = 1'b0;
        end
        else if (bus_stop)
        begin
            next_state = CCIS_IDLE;
            next_oe = 1'b0;
            if (prog.active)
            begin
                next_prog.active = 1'b0;
                next_last = prog.nib;
                case (prog.nib)
                    NIB_CODE_MSB: next_store[8] = prog.data[0];
                    NIB_CODE_HI:  next_store[7:4] = prog.data;
                    default:      next_store[3:0] = prog.data;
                endcase
            end
        end
        else
        begin
            case (state)
                CCIS_ADDR, CCIS_CMD_HI, CCIS_CMD_LO:
                begin
                    if (scl_rise && !byte_done)
                    begin
                        next_shreg = {shreg[BYTE_W-2:0], sda_s2};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    else if (scl_fall && byte_done)
                    begin
                        next_oe = 1'b1;
                        if (state == CCIS_ADDR)
                        begin
                            if (shreg[BYTE_W-1:1] == DEV_ADDR)
                                next_state = CCIS_ACK_ADDR;
                            else
                            begin
                                next_oe = 1'b0;
                                next_state = CCIS_IGNORE;
                            end
                        end
                        else if (state == CCIS_CMD_HI)
                        begin
                            next_cmd.hi = shreg;
                            next_state = CCIS_ACK_HI;
                        end
                        else
                        begin
                            next_cmd.lo = shreg;
                            next_state = CCIS_ACK_LO;
                        end
                    end
                end
                CCIS_ACK_ADDR, CCIS_ACK_HI, CCIS_ACK_LO:
                begin
                    if (scl_fall)
                    begin
                        next_oe = 1'b0;
                        next_bitcnt = '0;
                        next_state = CCIS_CMD_LO;
                        if (state == CCIS_ACK_ADDR)
                        begin
                            if (shreg[0])
                            begin
                                // read: latch store; reply bytes are not served
                                next_ctrl = retained_code_store;
                                next_state = CCIS_IGNORE;
                            end
                            else
                                next_state = CCIS_CMD_HI;
                        end
                        else if (state == CCIS_ACK_LO)
                        begin
                            // filler bytes go unanswered so they cannot re-run the command
                            next_state = CCIS_IGNORE;
                            if (!cmd.hi[HI_TARGET_BIT])
                            begin
                                next_work = {cmd.hi[HI_VMSB_BIT], cmd.lo};
                                next_ret = 1'b0;
                            end
                            else if (cmd.hi[7:4] == CMD_SET_RETAINED)
                                next_ret = 1'b1;
                            else if (!cmd.hi[HI_SETRET_BIT] &&
                                     cmd.hi[HI_NIB_MSB:HI_NIB_LSB] != 2'h3)
                            begin
                                next_prog.active = 1'b1;
                                next_prog.nib = cmd.hi[HI_NIB_MSB:HI_NIB_LSB];
                                next_prog.data = cmd.lo[NIB_W-1:0];
                            end
                        end
                    end
                end
                default:
                    next_oe = 1'b0;
            endcase
        end
        next_cap = next_ret ? next_ctrl : next_work;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state <= CCIS_IDLE;
            bitcnt <= '0;
            shreg <= '0;
            cmd <= '0;
            prog <= '0;
            ctrl <= STORE_INIT;
            working_code_register <= WORK_RESET;
            retained_code_store <= STORE_INIT;
            last_nibble <= NIB_CODE_LO;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            retained_mode <= 1'b1;
            capacitor_code <= STORE_INIT;
        end
        else if (ce)
        begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            cmd <= next_cmd;
            prog <= next_prog;
            ctrl <= next_ctrl;
            working_code_register <= next_work;
            retained_code_store <= next_store;
            last_nibble <= next_last;
            sda_oe <= next_oe;
            sda_out <= 1'b0;
            retained_mode <= next_ret;
            capacitor_code <= next_cap;
        end
    end

    assign prog_active = prog.active;

    // ********************************
    // checks
    // ********************************
    logic quiet, lo_done;
    assign quiet = ce && !bus_start && !bus_stop;
    assign lo_done = quiet && scl_fall && state == CCIS_ACK_LO;

    only_ack_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sda_oe |-> state inside {CCIS_ACK_ADDR, CCIS_ACK_HI, CCIS_ACK_LO})
        else $error("data driven outside an ack slot");
    ack_held_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        quiet && scl_fall && byte_done && state inside {CCIS_CMD_HI, CCIS_CMD_LO}
        |=> sda_oe && !scl_s2)
        else $error("command byte not acknowledged");
    addr_miss_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        quiet && scl_fall && byte_done && state == CCIS_ADDR && shreg[7:1] != DEV_ADDR
        |=> !sda_oe && state == CCIS_IGNORE)
        else $error("foreign address acknowledged");
    vol_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        lo_done && !cmd.hi[7]
        |=> working_code_register == {$past(cmd.hi[0]), $past(cmd.lo)} && !retained_mode)
        else $error("volatile write not applied");
    set_ret_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        lo_done && cmd.hi[7:4] == CMD_SET_RETAINED
        |=> retained_mode && $stable(working_code_register))
        else $error("set retained mode failed");
    nv_keep_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        lo_done && cmd.hi[7] && !cmd.hi[4] && cmd.hi[6:5] != 2'h3
        |=> $stable(retained_mode) && prog_active)
        else $error("retained write mishandled");
    prog_end_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && bus_stop && prog_active |=> !prog_active ##0 last_nibble == $past(prog.nib))
        else $error("programming not ended at stop");
    store_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && !(bus_stop && prog_active) |=> $stable(retained_code_store))
        else $error("retained store changed outside stop");
    read_copy_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        quiet && scl_fall && state == CCIS_ACK_ADDR && shreg[0]
        |=> ctrl == $past(retained_code_store))
        else $error("read did not load control register");
    cap_select_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce ##1 1'b1 |-> capacitor_code == (retained_mode ? ctrl : working_code_register))
        else $error("capacitor code from wrong source");

endmodule : ccis_slave

// [shared/ccis_pkg.sv]
// shared constants, types and state encoding for the capacitor code serial slave
package ccis_pkg;

    // ********************************
    // code and byte layout
    // ********************************
    localparam int CODE_W       = 9;
    localparam int BYTE_W       = 8;
    localparam int NIB_W        = 4;
    localparam int ADDR_W       = 7;
    localparam int BITCNT_W     = 4;
    localparam logic [BITCNT_W-1:0] BITS_PER_BYTE = 4'h8;

    // high command byte fields
    localparam int HI_TARGET_BIT = 7;   // memory_target_select
    localparam int HI_NIB_MSB    = 6;
    localparam int HI_NIB_LSB    = 5;
    localparam int HI_SETRET_BIT = 4;
    localparam int HI_VMSB_BIT   = 0;
    localparam logic [3:0] CMD_SET_RETAINED = 4'h9;

    // retained nibble addresses
    localparam logic [1:0] NIB_CODE_MSB = 2'h2;
    localparam logic [1:0] NIB_CODE_HI  = 2'h1;
    localparam logic [1:0] NIB_CODE_LO  = 2'h0;

    // reset values
    localparam logic [CODE_W-1:0] WORK_RESET = 9'h000;

    // ********************************
    // types
    // ********************************
    typedef enum logic [2:0] {
        CCIS_IDLE,
        CCIS_ADDR,
        CCIS_ACK_ADDR,
        CCIS_CMD_HI,
        CCIS_ACK_HI,
        CCIS_CMD_LO,
        CCIS_ACK_LO,
        CCIS_IGNORE
    } ccis_state_t;

    typedef struct packed {
        logic [BYTE_W-1:0] hi;
        logic [BYTE_W-1:0] lo;
    } ccis_cmd_t;

    typedef struct packed {
        logic              active;
        logic [1:0]        nib;
        logic [NIB_W-1:0]  data;
    } ccis_prog_t;

endpackage : ccis_pkg

// [verif/ccis_master_model.sv]
// serial bus master model that drives clock and data towards the slave
`timescale 1ns/10ps
module ccis_master_model
(
    // launch alignment
    input  wire logic clk_sys,
    // serial pins
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_wire
);
    // ********************************
    // bus phases, quarter period 40 ns
    // ********************************
    localparam time QTR = 40;

    initial
    begin
        scl     = 1'b1;  // idle bus: pull-ups hold both lines high
        sda_drv = 1'b1;
    end

    task automatic start_cond();
        @(posedge clk_sys);
        #1;
        sda_drv = 1'b1;
        scl     = 1'b1;
        #(2*QTR);
        sda_drv = 1'b0;
        #(2*QTR);
        scl     = 1'b0;
        #QTR;
    endtask : start_cond

    task automatic stop_cond();
        @(posedge clk_sys);
        #1;
        sda_drv = 1'b0;
        #QTR;
        scl     = 1'b1;
        #(2*QTR);
        sda_drv = 1'b1;
        #(2*QTR);
    endtask : stop_cond

    // eight bits msb first, then a released ninth clock; ack is seen mid-high
    task automatic xfer_byte(input logic [7:0] b, output logic ack);
        @(posedge clk_sys);
        #1;
        for (int i = 7; i >= 0; i--)
        begin
            sda_drv = b[i];
            #QTR;
            scl = 1'b1;
            #(2*QTR);
            scl = 1'b0;
            #QTR;
        end
        sda_drv = 1'b1;
        #QTR;
        scl = 1'b1;
        #QTR;
        ack = ~sda_wire;
        #QTR;
        scl = 1'b0;
        #QTR;
    endtask : xfer_byte
endmodule : ccis_master_model

// [verif/tb_top.sv]
// self-checking bench for the capacitor code serial slave
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import ccis_pkg::*;
    // ********************************
    // harness
    // ********************************
    localparam logic [ADDR_W-1:0] DEV = 7'h2A;  // arbitrary select address
    localparam logic [CODE_W-1:0] INIT = 9'h15A;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic scl, sda_drv, sda_out, sda_oe, retained_mode, prog_active, ack;
    logic [CODE_W-1:0] capacitor_code, working_code_register, retained_code_store;
    logic [1:0] last_nibble;
    int fails = 0;
    int checks_done = 0;
    wire sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    ccis_slave #(.DEV_ADDR(DEV), .STORE_INIT(INIT)) uut (.clk_sys(clk_sys), .nrst(nrst),
        .ce(ce), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .capacitor_code(capacitor_code), .retained_mode(retained_mode),
        .working_code_register(working_code_register),
        .retained_code_store(retained_code_store), .prog_active(prog_active),
        .last_nibble(last_nibble));
    ccis_master_model mst (.clk_sys(clk_sys), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_line));

    // address byte then both command bytes; a foreign address expects no ack
    task automatic write_cmd(input logic [7:0] hi, input logic [7:0] lo, input logic exp);
        mst.start_cond();
        mst.xfer_byte({(exp ? DEV : DEV ^ 7'h01), 1'b0}, ack);
        `CHK("addr ack", exp, ack)
        mst.xfer_byte(hi, ack);
        `CHK("hi ack", exp, ack)
        mst.xfer_byte(lo, ack);
        `CHK("lo ack", exp, ack)
    endtask : write_cmd

    task automatic t_reset_values();
        `CHK("mode", 1'b1, retained_mode)
        `CHK("working", WORK_RESET, working_code_register)
        `CHK("cap", INIT, capacitor_code)
        `CHK("oe", 1'b0, sda_oe)
        `CHK("drive", 1'b0, sda_out)
        $display("done reset");
    endtask : t_reset_values

    // ignored high bits set first, then the advised all-zero form
    task automatic t_volatile();
        write_cmd(8'h7E, 8'h3C, 1'b1);
        mst.stop_cond();
        `CHK("working", 9'h03C, working_code_register)
        write_cmd(8'h01, 8'hA5, 1'b1);
        mst.stop_cond();
        `CHK("working", 9'h1A5, working_code_register)
        `CHK("mode", 1'b0, retained_mode)
        `CHK("cap", 9'h1A5, capacitor_code)
        $display("done volatile");
    endtask : t_volatile

    // three nibbles, erase included, while in volatile mode
    task automatic t_retained();
        logic [7:0] his [3] = '{8'hAF, 8'hC0, 8'h80};
        logic [7:0] los [3] = '{8'hF3, 8'h00, 8'hF0};
        logic [CODE_W-1:0] exs [3] = '{9'h13A, 9'h03A, 9'h030};
        for (int k = 0; k < 3; k++)
        begin
            write_cmd(his[k], los[k], 1'b1);
            mst.xfer_byte(8'h00, ack);  // filler, 5 ms hold shortened
            `CHK("prog on", 1'b1, prog_active)
            mst.stop_cond();
            `CHK("prog off", 1'b0, prog_active)
            `CHK("store", exs[k], retained_code_store)
            `CHK("nibble", his[k][6:5], last_nibble)
            `CHK("mode", 1'b0, retained_mode)
            `CHK("cap", 9'h1A5, capacitor_code)
        end
        $display("done retained");
    endtask : t_retained

    // malformed retained writes, then set-retained and a read
    task automatic t_setret();
        write_cmd(8'hE0, 8'h0F, 1'b1);
        mst.stop_cond();
        write_cmd(8'hB0, 8'h0F, 1'b1);
        mst.stop_cond();
        `CHK("store kept", 9'h030, retained_code_store)
        write_cmd(8'h9F, 8'h55, 1'b1);
        mst.stop_cond();
        `CHK("mode", 1'b1, retained_mode)
        `CHK("working", 9'h1A5, working_code_register)
        `CHK("cap old", INIT, capacitor_code)
        mst.start_cond();
        mst.xfer_byte({DEV, 1'b1}, ack);
        `CHK("read ack", 1'b1, ack)
        mst.stop_cond();
        `CHK("cap new", 9'h030, capacitor_code)
        $display("done setret");
    endtask : t_setret

    task automatic t_mismatch();
        write_cmd(8'h01, 8'h11, 1'b0);
        mst.stop_cond();
        `CHK("working", 9'h1A5, working_code_register)
        `CHK("mode", 1'b1, retained_mode)
        $display("done mismatch");
    endtask : t_mismatch

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        t_reset_values();
        t_volatile();
        t_retained();
        t_setret();
        t_mismatch();
        results();
    end

    // the sequence takes about 50 us; a hang is cut well beyond that
    initial
    begin
        #300000;
        fails++;
        results();
    end
endmodule : tb_top
